// ### include/iaem_defs.svh
`ifndef IAEM_DEFS_SVH
`define IAEM_DEFS_SVH

// ----------------------------------------------------------------
// Table geometry and address map
// ----------------------------------------------------------------
`define IAEM_NUM_ENT      4
`define IAEM_WPE          8
`define IAEM_TBL_WORDS    32
`define IAEM_OFF_HIT_CNT  12'h100
`define IAEM_OFF_DROP_CNT 12'h104
`define IAEM_OFF_LAST     12'h108
`define IAEM_OFF_CTRL     12'h10C

// ----------------------------------------------------------------
// Word index inside one entry
// ----------------------------------------------------------------
`define IAEM_W_CTL        0
`define IAEM_W_FLAGS      1
`define IAEM_W_SRC_ADDR   2
`define IAEM_W_SOURCE_ADDRESS_MASK 3
`define IAEM_W_DST_ADDR   4
`define IAEM_W_DESTINATION_ADDRESS_MASK 5
`define IAEM_W_SPORT      6
`define IAEM_W_DPORT      7

// ----------------------------------------------------------------
// Entry control word fields
// ----------------------------------------------------------------
`define IAEM_B_EN         0
`define IAEM_B_DENY       1
`define IAEM_B_SHUT       2
`define IAEM_B_PROTO_USER 3
`define IAEM_F_PROTO      11:4
`define IAEM_B_SRC_USER   12
`define IAEM_B_DST_USER   13
`define IAEM_F_SPORT_MODE 15:14
`define IAEM_F_DPORT_MODE 17:16

// ----------------------------------------------------------------
// Reset values and protocol constants
// ----------------------------------------------------------------
`define IAEM_RST_CTRL     32'h0000_0001
`define IAEM_PROTO_TCP    8'h06
`define IAEM_RESP_OKAY    2'h0
`define IAEM_RESP_SLVERR  2'h2

`endif

// ### include/iaem_pkg.sv
package iaem_pkg;

    typedef logic [31:0] iaem_word_t;

    typedef enum logic [1:0] {
        IAEM_PM_ANY    = 2'h0,
        IAEM_PM_SINGLE = 2'h1,
        IAEM_PM_RANGE  = 2'h2,
        IAEM_PM_RSVD   = 2'h3
    } iaem_pmode_e;

    typedef enum logic [1:0] {
        IAEM_FL_DC    = 2'h0,
        IAEM_FL_SET   = 2'h1,
        IAEM_FL_UNSET = 2'h2,
        IAEM_FL_RSVD  = 2'h3
    } iaem_flag_e;

    // Flags order: [5] urgent [4] ack [3] push [2] reset [1] sync [0] finish
    typedef struct packed {
        logic [7:0]  proto;
        logic [31:0] src_addr;
        logic [31:0] dst_addr;
        logic [15:0] sport;
        logic [15:0] dport;
        logic [5:0]  tcp_flags;
    } iaem_hdr_s;

    typedef struct packed {
        logic       hit;
        logic [1:0] idx;
        logic       forward;
        logic       learn;
        logic       drop;
    } iaem_res_s;

endpackage

// ### rtl/iaem_matcher.sv
`timescale 1ns/1ps
`include "iaem_defs.svh"
// What this block does
// - Permit hit: forward and learn frame
// - Deny hit: drop frame, never forward
// - Shutdown option never disables a port
// - Any protocol: protocol field not compared
// - Given protocol id must equal frame's
// - Any source address: source ignored
// - User source address must equal frame's outside its own mask
// - Any destination address: destination ignored
// - User destination address must equal frame's
// - Destination compare qualified by own mask
// - Any source port: don't care
// - Single source port must equal value
// - Range source port within lower, upper
// - Destination port any, single, range modes
// - Urgent flag set or unset matching
// - Don't-care flag accepts any value
// - Same matching for five other flags
module iaem_matcher
    import iaem_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic [11:0] i_axi_awaddr,
    input  wire logic        i_axi_awvalid,
    output logic             o_axi_awready,
    input  wire logic [31:0] i_axi_wdata,
    input  wire logic [3:0]  i_axi_wstrb,
    input  wire logic        i_axi_wvalid,
    output logic             o_axi_wready,
    output logic [1:0]       o_axi_bresp,
    output logic             o_axi_bvalid,
    input  wire logic        i_axi_bready,
    input  wire logic [11:0] i_axi_araddr,
    input  wire logic        i_axi_arvalid,
    output logic             o_axi_arready,
    output logic [31:0]      o_axi_rdata,
    output logic [1:0]       o_axi_rresp,
    output logic             o_axi_rvalid,
    input  wire logic        i_axi_rready,
    input  wire logic        i_frm_valid,
    input  wire iaem_hdr_s   i_frm_hdr,
    output logic             o_res_valid,
    output iaem_res_s        o_res
);

    // ----------------------------------------------------------------
    // Match helpers
    // ----------------------------------------------------------------
    function automatic logic addr_ok(input logic [31:0] a, input logic [31:0] v,
                                     input logic [31:0] m);
        addr_ok = ((a ^ v) & ~m) == 32'h0000_0000;
    endfunction

    function automatic logic port_ok(input logic [1:0] mode, input logic [15:0] p,
                                     input logic [31:0] lohi);
        case (mode)
            IAEM_PM_SINGLE: port_ok = (p == lohi[15:0]);
            IAEM_PM_RANGE:  port_ok = (p >= lohi[15:0]) && (p <= lohi[31:16]);
            default:        port_ok = 1'b1;
        endcase
    endfunction

    function automatic logic flag_ok(input logic [1:0] mode, input logic f,
                                     input logic tcp);
        case (mode)
            IAEM_FL_SET:   flag_ok = tcp && f;
            IAEM_FL_UNSET: flag_ok = !(tcp && f);
            default:       flag_ok = 1'b1;
        endcase
    endfunction

    function automatic logic is_ent(input logic [11:0] a);
        is_ent = (a[11:7] == 5'h00);
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    iaem_word_t tbl_q [`IAEM_TBL_WORDS];
    iaem_word_t tbl_d [`IAEM_TBL_WORDS];
    logic [31:0] ctrl_q, ctrl_d, hit_cnt_q, hit_cnt_d, drop_cnt_q, drop_cnt_d;
    logic        awrdy_q, awrdy_d, brsp_v_q, brsp_v_d, arrdy_q, arrdy_d;
    logic        rv_q, rv_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic        res_v_q, res_v_d;
    iaem_res_s   res_q, res_d;

    logic [`IAEM_NUM_ENT-1:0] hit_vec;
    logic [1:0]               sel;
    logic                     sel_deny;
    logic                     any_hit;
    logic                     is_tcp;

    // ----------------------------------------------------------------
    // Entry compare
    // ----------------------------------------------------------------
    always_comb
    begin
        iaem_word_t ctl;
        iaem_word_t flg;
        ctl    = 32'h0000_0000;
        flg    = 32'h0000_0000;
        is_tcp = (i_frm_hdr.proto == `IAEM_PROTO_TCP);
        for (int e = 0; e < `IAEM_NUM_ENT; e++)
        begin
            ctl = tbl_q[e*`IAEM_WPE + `IAEM_W_CTL];
            flg = tbl_q[e*`IAEM_WPE + `IAEM_W_FLAGS];
            hit_vec[e] = ctl[`IAEM_B_EN]
                && (!ctl[`IAEM_B_PROTO_USER]
                    || i_frm_hdr.proto == ctl[`IAEM_F_PROTO])
                && (!ctl[`IAEM_B_SRC_USER]
                    || addr_ok(i_frm_hdr.src_addr, tbl_q[e*`IAEM_WPE + `IAEM_W_SRC_ADDR],
                        tbl_q[e*`IAEM_WPE + `IAEM_W_SOURCE_ADDRESS_MASK]))
                && (!ctl[`IAEM_B_DST_USER]
                    || addr_ok(i_frm_hdr.dst_addr, tbl_q[e*`IAEM_WPE + `IAEM_W_DST_ADDR],
                        tbl_q[e*`IAEM_WPE + `IAEM_W_DESTINATION_ADDRESS_MASK]))
                && port_ok(ctl[`IAEM_F_SPORT_MODE], i_frm_hdr.sport,
                           tbl_q[e*`IAEM_WPE + `IAEM_W_SPORT])
                && port_ok(ctl[`IAEM_F_DPORT_MODE], i_frm_hdr.dport,
                           tbl_q[e*`IAEM_WPE + `IAEM_W_DPORT]);
            for (int f = 0; f < 6; f++)
            begin
                hit_vec[e] = hit_vec[e]
                    && flag_ok(flg[2*f +: 2], i_frm_hdr.tcp_flags[f], is_tcp);
            end
        end
    end

    // ----------------------------------------------------------------
    // Priority select and result
    // ----------------------------------------------------------------
    always_comb
    begin
        sel = 2'h0;
        for (int e = `IAEM_NUM_ENT - 1; e >= 0; e--)
        begin
            if (hit_vec[e])
            begin
                sel = 2'(e);
            end
        end
        any_hit  = (|hit_vec) && ctrl_q[0];
        sel_deny = tbl_q[{sel, 3'h0}][`IAEM_B_DENY];
        res_v_d  = i_frm_valid;
        res_d    = res_q;
        if (i_frm_valid)
        begin
            res_d.hit     = any_hit;
            res_d.idx     = any_hit ? sel : 2'h0;
            // Shutdown option is stored only; no port is ever disabled
            res_d.drop    = any_hit && sel_deny;
            res_d.forward = !(any_hit && sel_deny);
            res_d.learn   = !(any_hit && sel_deny);
        end
        hit_cnt_d  = hit_cnt_q + 32'(i_frm_valid && any_hit);
        drop_cnt_d = drop_cnt_q + 32'(i_frm_valid && any_hit && sel_deny);
    end

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    // Both address and data must be offered before the write is taken
    always_comb
    begin
        logic wr_fire;
        wr_fire  = awrdy_q;
        tbl_d    = tbl_q;
        ctrl_d   = ctrl_q;
        awrdy_d  = i_axi_awvalid && i_axi_wvalid && !awrdy_q && !brsp_v_q;
        brsp_v_d = wr_fire || (brsp_v_q && !i_axi_bready);
        bresp_d  = bresp_q;
        if (wr_fire)
        begin
            bresp_d = `IAEM_RESP_OKAY;
            if (is_ent(i_axi_awaddr))
            begin
                for (int b = 0; b < 4; b++)
                begin
                    if (i_axi_wstrb[b])
                    begin
                        tbl_d[i_axi_awaddr[6:2]][8*b +: 8] = i_axi_wdata[8*b +: 8];
                    end
                end
            end
            else if (i_axi_awaddr == `IAEM_OFF_CTRL)
            begin
                if (i_axi_wstrb[0])
                begin
                    ctrl_d = {31'h0, i_axi_wdata[0]};
                end
            end
            else if (i_axi_awaddr != `IAEM_OFF_HIT_CNT
                     && i_axi_awaddr != `IAEM_OFF_DROP_CNT
                     && i_axi_awaddr != `IAEM_OFF_LAST)
            begin
                bresp_d = `IAEM_RESP_SLVERR;
            end
        end
    end

    always_comb
    begin
        arrdy_d = i_axi_arvalid && !arrdy_q && !rv_q;
        rv_d    = arrdy_q || (rv_q && !i_axi_rready);
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (arrdy_q)
        begin
            rresp_d = `IAEM_RESP_OKAY;
            rdata_d = 32'h0000_0000;
            if (is_ent(i_axi_araddr))
            begin
                rdata_d = tbl_q[i_axi_araddr[6:2]];
            end
            else
            begin
                case (i_axi_araddr)
                    `IAEM_OFF_HIT_CNT:  rdata_d = hit_cnt_q;
                    `IAEM_OFF_DROP_CNT: rdata_d = drop_cnt_q;
                    `IAEM_OFF_LAST:     rdata_d = {26'h0, res_q};
                    `IAEM_OFF_CTRL:     rdata_d = ctrl_q;
                    default:            rresp_d = `IAEM_RESP_SLVERR;
                endcase
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (int i = 0; i < `IAEM_TBL_WORDS; i++)
            begin
                tbl_q[i] <= 32'h0000_0000;
            end
            ctrl_q     <= `IAEM_RST_CTRL;
            hit_cnt_q  <= 32'h0000_0000;
            drop_cnt_q <= 32'h0000_0000;
            awrdy_q    <= 1'b0;
            brsp_v_q   <= 1'b0;
            bresp_q    <= 2'h0;
            arrdy_q    <= 1'b0;
            rv_q       <= 1'b0;
            rresp_q    <= 2'h0;
            rdata_q    <= 32'h0000_0000;
            res_v_q    <= 1'b0;
            res_q      <= 6'h00;
        end
        else
        begin
            tbl_q      <= tbl_d;
            ctrl_q     <= ctrl_d;
            hit_cnt_q  <= hit_cnt_d;
            drop_cnt_q <= drop_cnt_d;
            awrdy_q    <= awrdy_d;
            brsp_v_q   <= brsp_v_d;
            bresp_q    <= bresp_d;
            arrdy_q    <= arrdy_d;
            rv_q       <= rv_d;
            rresp_q    <= rresp_d;
            rdata_q    <= rdata_d;
            res_v_q    <= res_v_d;
            res_q      <= res_d;
        end
    end

    assign o_axi_awready = awrdy_q;
    assign o_axi_wready  = awrdy_q;
    assign o_axi_bvalid  = brsp_v_q;
    assign o_axi_bresp   = bresp_q;
    assign o_axi_arready = arrdy_q;
    assign o_axi_rvalid  = rv_q;
    assign o_axi_rresp   = rresp_q;
    assign o_axi_rdata   = rdata_q;
    assign o_res_valid   = res_v_q;
    assign o_res         = res_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    property p_permit;
        i_frm_valid && any_hit && !sel_deny |=> o_res.forward && o_res.learn && o_res.hit;
    endproperty
    a_permit: assert property (p_permit) else $error("permit hit not forwarded");

    property p_deny;
        i_frm_valid && any_hit && sel_deny |=> o_res.drop && !o_res.forward;
    endproperty
    a_deny: assert property (p_deny) else $error("deny hit not dropped");

    property p_miss;
        o_res_valid && !o_res.hit |-> o_res.forward && !o_res.drop;
    endproperty
    a_miss: assert property (p_miss) else $error("missed frame not passed");

    property p_first;
        i_frm_valid && ctrl_q[0] && hit_vec[0] |=> o_res_valid && o_res.idx == 2'h0;
    endproperty
    a_first: assert property (p_first) else $error("lowest entry not chosen");

    property p_proto;
        tbl_q[0][`IAEM_B_PROTO_USER]
            && i_frm_hdr.proto != tbl_q[0][`IAEM_F_PROTO] |-> !hit_vec[0];
    endproperty
    a_proto: assert property (p_proto) else $error("protocol mismatch hit");

    property p_src_addr;
        tbl_q[0][`IAEM_B_SRC_USER]
            && ((i_frm_hdr.src_addr ^ tbl_q[2]) & ~tbl_q[3]) != 32'h0 |-> !hit_vec[0];
    endproperty
    a_src_addr: assert property (p_src_addr) else $error("source address mismatch hit");

    property p_sport;
        tbl_q[0][`IAEM_F_SPORT_MODE] == IAEM_PM_SINGLE
            && i_frm_hdr.sport != tbl_q[6][15:0] |-> !hit_vec[0];
    endproperty
    a_sport: assert property (p_sport) else $error("source port mismatch hit");

    property p_urg;
        tbl_q[1][11:10] == IAEM_FL_SET && !i_frm_hdr.tcp_flags[5] |-> !hit_vec[0];
    endproperty
    a_urg: assert property (p_urg) else $error("urgent flag mismatch hit");

    property p_cnt;
        i_frm_valid && any_hit && sel_deny |=> drop_cnt_q == $past(drop_cnt_q) + 32'h1;
    endproperty
    a_cnt: assert property (p_cnt) else $error("drop count not advanced");

endmodule

// ### testbench/iaem_fwd_model.sv
`timescale 1ns/1ps
// ----------
// Forwarding path: tallies the verdicts it is handed
// ----------
module iaem_fwd_model
    import iaem_pkg::*;
(
    input  wire logic      i_core_clk,
    input  wire logic      i_rst_n,
    input  wire logic      i_res_valid,
    input  wire iaem_res_s i_res
);
    int fwd_cnt;
    int drop_cnt;

    // No back-pressure: every verdict is consumed in its own cycle
    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            fwd_cnt = 0;
            drop_cnt = 0;
        end
        else if (i_res_valid)
        begin
            if (i_res.drop)
                drop_cnt++;
            if (i_res.forward && i_res.learn)
                fwd_cnt++;
        end
    end
endmodule

// ### testbench/iaem_matcher_bench.sv
`timescale 1ns/1ps
module iaem_matcher_bench
    import iaem_pkg::*;
;
    logic        i_core_clk = 1'h0;
    logic        i_rst_n = 1'h0;
    logic [11:0] aw_a = 12'h0, ar_a = 12'h0;
    logic [31:0] w_d = 32'h0;
    logic        awv = 1'h0, wv = 1'h0, brdy = 1'h0, arv = 1'h0, rrdy = 1'h0;
    logic        awr, wr, bv, arr, rv, i_frm_valid = 1'h0, o_res_valid;
    logic [1:0]  br, rr;
    logic [31:0] rd;
    iaem_hdr_s   i_frm_hdr = '0;
    iaem_res_s   o_res, last_e;
    logic [31:0] tbl [32];
    logic [15:0] pp [4] = '{16'h0000, 16'h0001, 16'h0002, 16'hFFFF};
    logic [31:0] seed_q = 32'h0000_0032;
    logic        ctrl_en = 1'h1;
    int          miscompares = 0, tests_run = 0, hits_exp = 0, drops_exp = 0, fwds_exp = 0;

    always #2.5 i_core_clk = ~i_core_clk;

    iaem_matcher dut_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_axi_awaddr(aw_a), .i_axi_awvalid(awv), .o_axi_awready(awr),
        .i_axi_wdata(w_d), .i_axi_wstrb(4'hF), .i_axi_wvalid(wv), .o_axi_wready(wr),
        .o_axi_bresp(br), .o_axi_bvalid(bv), .i_axi_bready(brdy),
        .i_axi_araddr(ar_a), .i_axi_arvalid(arv), .o_axi_arready(arr),
        .o_axi_rdata(rd), .o_axi_rresp(rr), .o_axi_rvalid(rv), .i_axi_rready(rrdy),
        .i_frm_valid(i_frm_valid), .i_frm_hdr(i_frm_hdr),
        .o_res_valid(o_res_valid), .o_res(o_res));

    iaem_fwd_model fwd_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_res_valid(o_res_valid), .i_res(o_res));

    // ----------
    // Reference and stimulus helpers
    // ----------
    function automatic logic [31:0] rnd();
        seed_q ^= seed_q << 13;
        seed_q ^= seed_q >> 17;
        seed_q ^= seed_q << 5;
        return seed_q;
    endfunction

    function automatic logic port_ok(logic [1:0] m, logic [15:0] p, logic [31:0] w);
        if (m == 2'h1)
            return p == w[15:0];
        if (m == 2'h2)
            return p >= w[15:0] && p <= w[31:16];
        return 1'h1;
    endfunction

    // Walk from the top entry down so the lowest matching index is kept
    function automatic iaem_res_s ref_res(iaem_hdr_s h);
        iaem_res_s   r;
        logic        ok, fb;
        logic [31:0] c;
        logic [1:0]  fc;
        r = '{1'h0, 2'h0, 1'h1, 1'h1, 1'h0};
        for (int e = 3; e >= 0; e--)
        begin
            c = tbl[e*8];
            ok = c[0];
            if (c[3] && h.proto != c[11:4]) ok = 1'h0;
            if (c[12] && ((h.src_addr ^ tbl[e*8+2]) & ~tbl[e*8+3]) != 32'h0) ok = 1'h0;
            if (c[13] && ((h.dst_addr ^ tbl[e*8+4]) & ~tbl[e*8+5]) != 32'h0) ok = 1'h0;
            if (!port_ok(c[15:14], h.sport, tbl[e*8+6])) ok = 1'h0;
            if (!port_ok(c[17:16], h.dport, tbl[e*8+7])) ok = 1'h0;
            for (int f = 0; f < 6; f++)
            begin
                fc = tbl[e*8+1][2*f +: 2];
                fb = h.proto == 8'h06 && h.tcp_flags[f];
                if ((fc == 2'h1 && !fb) || (fc == 2'h2 && fb)) ok = 1'h0;
            end
            if (ok && ctrl_en) r = '{1'h1, 2'(e), ~c[1], ~c[1], c[1]};
        end
        return r;
    endfunction

    task automatic chk_res(iaem_res_s e);
        tests_run++;
        if ({o_res_valid, o_res} !== {1'h1, e})
        begin
            miscompares++;
            $display("[FAIL] %0t result %h exp %h", $time, o_res, e);
        end
    endtask

    task automatic chk_word(logic [31:0] g, logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] %0t word %h exp %h", $time, g, e);
        end
    endtask

    task automatic axi_wr(logic [11:0] a, logic [31:0] d);
        @(posedge i_core_clk);
        aw_a <= a; w_d <= d; awv <= 1'h1; wv <= 1'h1; brdy <= 1'h1;
        do @(posedge i_core_clk); while (!(awr && wr));
        awv <= 1'h0; wv <= 1'h0;
        while (!bv) @(posedge i_core_clk);
        chk_word({30'h0, br}, {30'h0, (a[11:8] == 4'h0 && a[7]) ? 2'h2 : 2'h0});
        brdy <= 1'h0;
    endtask

    task automatic axi_rd(logic [11:0] a, output logic [31:0] d);
        @(posedge i_core_clk);
        ar_a <= a; arv <= 1'h1; rrdy <= 1'h1;
        do @(posedge i_core_clk); while (!arr);
        arv <= 1'h0;
        while (!rv) @(posedge i_core_clk);
        d = rd;
        chk_word({30'h0, rr}, {30'h0, (a[11:8] == 4'h0 && a[7]) ? 2'h2 : 2'h0});
        rrdy <= 1'h0;
    endtask

    task automatic cfg_rand();
        logic [31:0] r, q, w;
        for (int i = 0; i < 32; i++)
        begin
            r = rnd();
            q = rnd();
            case (i % 8)
                0: w = {14'h0, r[17:12] & q[17:12], r[5] ? 8'h06 : 8'h11, r[3] & q[3],
                        r[2:1], |r[21:20]};
                1: w = r & q & 32'h0000_0FFF;
                2, 4: w = 32'hC0A8_0100 | {30'h0, r[1:0]};
                3, 5: w = r[2] ? 32'hFFFF_FFFF : {31'h0, r[0]};
                default: w = {pp[r[3:2]], pp[r[1:0]]};
            endcase
            tbl[i] = w;
            axi_wr(12'(i * 4), w);
        end
    endtask

    // Frames back to back: frame k launched on the edge that checks frame k-1
    task automatic burst(int n);
        iaem_hdr_s h;
        logic [31:0] r, q;
        for (int k = 0; k <= n; k++)
        begin
            @(posedge i_core_clk);
            r = rnd();
            q = rnd();
            h = '{r[0] ? 8'h06 : 8'h11, 32'hC0A8_0100 | {30'h0, r[2:1]},
                  32'hC0A8_0100 | {30'h0, r[4:3]}, pp[r[6:5]], pp[r[8:7]], q[5:0]};
            i_frm_hdr <= h;
            i_frm_valid <= k < n;
            #1;
            if (k > 0) chk_res(last_e);
            if (k < n) last_e = ref_res(h);
            if (k < n) hits_exp += last_e.hit;
            if (k < n) drops_exp += last_e.drop;
            if (k < n) fwds_exp += last_e.forward;
        end
    endtask

    task automatic final_report();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ----------
    // Test sequence
    // ----------
    initial
    begin
        repeat (40000) @(posedge i_core_clk);
        miscompares++;
        $display("[FAIL] %0t watchdog expired", $time);
        final_report();
    end

    initial
    begin
        logic [31:0] d;
        for (int i = 0; i < 32; i++) tbl[i] = 32'h0;
        repeat (20) @(posedge i_core_clk);
        i_rst_n <= 1'h1;
        axi_rd(12'h10C, d);
        chk_word(d, 32'h0000_0001);
        axi_rd(12'h100, d);
        chk_word(d, 32'h0);
        burst(2);
        $display("test reset done");
        for (int rnd_i = 0; rnd_i < 6; rnd_i++)
        begin
            cfg_rand();
            for (int b = 0; b < 20; b++) burst(1 + int'(rnd() % 4));
        end
        axi_rd(12'h00C, d);
        chk_word(d, tbl[3]);
        axi_rd(12'h108, d);
        chk_word(d, {26'h0, last_e});
        $display("test match done");
        axi_wr(12'h100, 32'hFFFF_FFFF);
        axi_rd(12'h100, d);
        chk_word(d, 32'(hits_exp));
        axi_rd(12'h104, d);
        chk_word(d, 32'(drops_exp));
        chk_word(32'(fwd_u.drop_cnt), 32'(drops_exp));
        chk_word(32'(fwd_u.fwd_cnt), 32'(fwds_exp));
        axi_wr(12'h080, 32'h1234_5678);
        axi_rd(12'h080, d);
        chk_word(d, 32'h0);
        axi_wr(12'h10C, 32'h0);
        ctrl_en = 1'h0;
        burst(3);
        $display("test control done");
        final_report();
    end
endmodule
